// [inc/core_map_pkg.sv]
/*
  core_map_pkg: constants and carrier types of the core memory map block.
  assumes: one core clock, one machine cycle per clock.
*/
package core_map_pkg;
  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_BASE = 8'h80; // start of sfr space
  localparam logic [7:0] SFR_SP = 8'h81; // stack_pointer_low
  localparam logic [7:0] SFR_DPL = 8'h82; // pointer_low_byte
  localparam logic [7:0] SFR_DPH = 8'h83; // pointer_high_byte
  localparam logic [7:0] SFR_DPP = 8'h84; // pointer_page_byte
  localparam logic [7:0] SFR_EXT_DATA_MOVE_WAIT_STATES = 8'h9f; // ext_data_move_wait_states
  localparam logic [7:0] SFR_CFG = 8'haf; // core_config_reg
  localparam logic [7:0] SFR_SPH = 8'hb7; // stack_pointer_high
  localparam logic [7:0] SFR_PSW = 8'hd0; // cpu_status_word
  localparam logic [7:0] SFR_ACC = 8'he0; // main_operand_reg
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SPH_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] EXT_DATA_MOVE_WAIT_STATES_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_XSTACK_BIT = 7; // extended stack enable
  localparam int CFG_XRAM_BIT = 0; // internal xram enable
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;
  // ---------------------------------------------------------------
  // memory map and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] BIT_AREA_BASE = 8'h20; // bit-addressable bytes
  localparam logic [15:0] NOP_AREA_START = 16'hf800; // fetches read nop
  localparam logic [7:0] NOP_OPCODE = 8'h00;
  localparam logic [23:0] XRAM_SIZE = 24'h000800; // 2 kbyte on chip
  localparam logic [3:0] MOVE_BASE_CYCLES = 4'h4;
  localparam logic [3:0] IRQ_CALL_CYCLES = 4'h3;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MEM_NONE = 3'b000, MEM_DIRECT = 3'b001, MEM_INDIRECT = 3'b010,
    MEM_BANKREG = 3'b011, MEM_BIT = 3'b100, MEM_STACK = 3'b101
  } mem_op_e;
  typedef enum logic [1:0] {
    INSTR_PLAIN = 2'b00, INSTR_EXT_MOVE = 2'b01, INSTR_IRQ_CALL = 2'b10
  } instr_kind_e;
  typedef struct packed {
    mem_op_e op; // access kind
    logic wr; // write (push for stack)
    logic [7:0] addr; // address, register index or bit address
    logic [7:0] wdata; // write data, bit value in bit 0
  } mem_req_s;
  typedef struct packed {
    instr_kind_e kind; // plain, ext_data_move or irq call
    logic [3:0] cycles; // length of a plain instruction
    logic ext_write; // ext_data_move direction
  } instr_req_s;
  typedef struct packed {
    logic [23:0] addr; // external data address
    logic [7:0] wdata; // write data
    logic rd_n; // read strobe, active low
    logic wr_n; // write strobe, active low
  } ext_bus_s;
endpackage : core_map_pkg

// [hw/core_map.sv]
/*
  core_map: instruction timing, address strobe, timer tick, internal ram,
  stack, data pointer, status word and external data moves of the core.
  assumes: the sequencer above issues one request a cycle on the same
  clock; external ram is asynchronous and settles within the strobe.
*/
`timescale 1ns/1ps
module core_map (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire core_map_pkg::instr_req_s instr_req_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  output logic ale_out,
  input wire logic timer_run_in,
  output logic [15:0] timer_count_out,
  input wire logic [15:0] code_addr_in,
  input wire logic [7:0] code_flash_in,
  output logic [7:0] code_data_out,
  input wire core_map_pkg::mem_req_s mem_req_in,
  output logic [7:0] mem_rdata_out,
  input wire logic inc_pointer_in,
  output logic [23:0] data_pointer_word_out,
  output logic [7:0] cpu_status_word_out,
  input wire logic [7:0] ext_data_in,
  output core_map_pkg::ext_bus_s ext_bus_out,
  output logic bus_ports_free_out
);
  // ---------------------------------------------------------------
  // storage and registers
  // ---------------------------------------------------------------
  logic [7:0] ram_q [256]; // general-purpose ram
  logic [7:0] xram_q [2048]; // internal xram
  logic [7:0] stack_ptr_low_q; // stack_ptr_low
  logic [7:0] stack_ptr_high_q; // stack_ptr_high
  logic [7:0] ext_data_move_wait_states_q;
  logic [7:0] core_config_reg_q;
  logic [7:1] status_q; // status word minus parity
  logic [7:0] main_operand_reg_q;
  logic [7:0] pointer_low_byte_q;
  logic [7:0] pointer_high_byte_q;
  logic [7:0] pointer_page_byte_q;
  logic [3:0] cyc_left_q; // cycles left in current instruction
  logic move_q; // ext_data_move in flight
  logic move_wr_q; // its direction
  logic move_int_q; // it targets internal xram
  logic [15:0] timer_q;
  logic [7:0] code_q;
  logic [7:0] rdata_q;
  core_map_pkg::ext_bus_s bus_q;
  logic ports_free_q;
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // length of an instruction in cycles
  function automatic logic [3:0] instr_len(
    input core_map_pkg::instr_req_s req, input logic [2:0] waits);
    unique case (req.kind)
      core_map_pkg::INSTR_EXT_MOVE:
        instr_len = core_map_pkg::MOVE_BASE_CYCLES + {1'b0, waits};
      core_map_pkg::INSTR_IRQ_CALL:
        instr_len = core_map_pkg::IRQ_CALL_CYCLES;
      default: instr_len = (req.cycles == 4'h0) ? 4'h1 : req.cycles;
    endcase
  endfunction : instr_len

  logic start; // first cycle of a new instruction
  logic xstack; // 11-bit stack active
  logic xram_en; // xram mapped on chip
  logic [10:0] sp_word; // full stack pointer
  logic [10:0] sp_next; // pointer after a push
  logic [10:0] sp_prev; // pointer after a pop
  logic [10:0] stack_addr; // slot the stack op touches
  logic stack_in_xram;
  logic [7:0] ram_idx;
  logic is_sfr;
  logic [7:0] sfr_rd;
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic byte_we;
  logic push;
  logic pop;
  logic [23:0] data_pointer_word;
  logic parity;

  assign parity = ^main_operand_reg_q;
  assign data_pointer_word = {pointer_page_byte_q, pointer_high_byte_q,
                 pointer_low_byte_q};
  assign xstack = core_config_reg_q[core_map_pkg::CFG_XSTACK_BIT];
  assign xram_en = core_config_reg_q[core_map_pkg::CFG_XRAM_BIT];
  assign sp_word = {stack_ptr_high_q[2:0], stack_ptr_low_q};
  assign push = mem_req_in.op == core_map_pkg::MEM_STACK && mem_req_in.wr;
  assign pop = mem_req_in.op == core_map_pkg::MEM_STACK && !mem_req_in.wr;
  assign start = instr_valid_in && cyc_left_q == 4'h0;
  assign instr_ready_out = cyc_left_q == 4'h0;

  // stack pointer arithmetic, 8-bit wrap or 11-bit span
  always_comb begin
    if (xstack) begin
      sp_next = sp_word + 11'h001;
      sp_prev = sp_word - 11'h001;
    end else begin
      sp_next = {sp_word[10:8], stack_ptr_low_q + 8'h01};
      sp_prev = {sp_word[10:8], stack_ptr_low_q - 8'h01};
    end
    stack_addr = push ? sp_next : sp_word;
    stack_in_xram = xstack && stack_addr[10:8] != 3'h0;
  end

  // sfr read mux; unmapped sfr addresses read zero
  always_comb begin
    unique case (ram_idx)
      core_map_pkg::SFR_SP: sfr_rd = stack_ptr_low_q;
      core_map_pkg::SFR_SPH: sfr_rd = stack_ptr_high_q;
      core_map_pkg::SFR_EXT_DATA_MOVE_WAIT_STATES: sfr_rd = ext_data_move_wait_states_q;
      core_map_pkg::SFR_CFG: sfr_rd = core_config_reg_q;
      core_map_pkg::SFR_PSW: sfr_rd = {status_q, parity};
      core_map_pkg::SFR_ACC: sfr_rd = main_operand_reg_q;
      core_map_pkg::SFR_DPL: sfr_rd = pointer_low_byte_q;
      core_map_pkg::SFR_DPH: sfr_rd = pointer_high_byte_q;
      core_map_pkg::SFR_DPP: sfr_rd = pointer_page_byte_q;
      default: sfr_rd = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // internal data space address decode
  // ---------------------------------------------------------------
  always_comb begin
    ram_idx = mem_req_in.addr;
    is_sfr = 1'b0;
    unique case (mem_req_in.op)
      core_map_pkg::MEM_DIRECT: is_sfr = mem_req_in.addr[7];
      core_map_pkg::MEM_INDIRECT: is_sfr = 1'b0;
      core_map_pkg::MEM_BANKREG:
        ram_idx = {3'h0, status_q[core_map_pkg::PSW_RS_HI],
                   status_q[core_map_pkg::PSW_RS_LO],
                   mem_req_in.addr[2:0]};
      core_map_pkg::MEM_BIT: begin
        is_sfr = mem_req_in.addr[7];
        ram_idx = mem_req_in.addr[7] ? {mem_req_in.addr[7:3], 3'h0}
          : core_map_pkg::BIT_AREA_BASE + {4'h0, mem_req_in.addr[6:3]};
      end
      core_map_pkg::MEM_STACK: ram_idx = stack_addr[7:0];
      default: ram_idx = mem_req_in.addr;
    endcase
    old_byte = is_sfr ? sfr_rd : ram_q[ram_idx];
    new_byte = mem_req_in.wdata;
    if (mem_req_in.op == core_map_pkg::MEM_BIT) begin
      new_byte = old_byte;
      new_byte[mem_req_in.addr[2:0]] = mem_req_in.wdata[0];
    end
    byte_we = mem_req_in.wr && mem_req_in.op != core_map_pkg::MEM_NONE;
  end

  // ---------------------------------------------------------------
  // instruction timing and address strobe
  // ---------------------------------------------------------------
  // counts the cycles left of the running instruction
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_left_q <= 4'h0;
    end else if (start) begin
      cyc_left_q <= instr_len(instr_req_in,
                              ext_data_move_wait_states_q[2:0]) - 4'h1;
    end else if (cyc_left_q != 4'h0) begin
      cyc_left_q <= cyc_left_q - 4'h1;
    end
  end
  // strobe is the clock high phase of the first cycle only
  assign ale_out = start & clk_sys_in;

  // timer ticks once per clock while timer_run_in is high, one machine cycle each
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_q <= 16'h0000;
    end else if (timer_run_in) begin
      timer_q <= timer_q + 16'h0001;
    end
  end
  assign timer_count_out = timer_q;

  // code fetch; the top 2 kbyte never reach off chip
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      code_q <= core_map_pkg::NOP_OPCODE;
    end else if (code_addr_in >= core_map_pkg::NOP_AREA_START) begin
      code_q <= core_map_pkg::NOP_OPCODE;
    end else begin
      code_q <= code_flash_in;
    end
  end
  assign code_data_out = code_q;

  // ---------------------------------------------------------------
  // external data moves
  // ---------------------------------------------------------------
  // strobes low from the second cycle to the last one
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      move_q <= 1'b0;
      move_wr_q <= 1'b0;
      move_int_q <= 1'b0;
      bus_q <= '{addr: 24'h000000, wdata: 8'h00, rd_n: 1'b1, wr_n: 1'b1};
    end else if (start
                 && instr_req_in.kind == core_map_pkg::INSTR_EXT_MOVE) begin
      move_q <= 1'b1;
      move_wr_q <= instr_req_in.ext_write;
      move_int_q <= xram_en && data_pointer_word < core_map_pkg::XRAM_SIZE;
      bus_q.addr <= data_pointer_word;
      bus_q.wdata <= main_operand_reg_q;
      if (!(xram_en && data_pointer_word < core_map_pkg::XRAM_SIZE)) begin
        bus_q.rd_n <= instr_req_in.ext_write;
        bus_q.wr_n <= !instr_req_in.ext_write;
      end
    end else if (move_q && cyc_left_q == 4'h1) begin
      move_q <= 1'b0;
      bus_q.rd_n <= 1'b1;
      bus_q.wr_n <= 1'b1;
    end
  end
  assign ext_bus_out = bus_q;

  // ports freed while xram is mapped and nothing goes off chip
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ports_free_q <= 1'b0;
    end else begin
      ports_free_q <= xram_en && bus_q.rd_n && bus_q.wr_n;
    end
  end
  assign bus_ports_free_out = ports_free_q;

  // ---------------------------------------------------------------
  // ram and xram arrays
  // ---------------------------------------------------------------
  // internal ram writes: direct, indirect, bank, bit and push
  always_ff @(posedge clk_sys_in) begin
    if (byte_we && !is_sfr && !(push && stack_in_xram)) begin
      ram_q[ram_idx] <= new_byte;
    end
  end
  // xram writes: extended stack and on-chip moves
  always_ff @(posedge clk_sys_in) begin
    if (push && stack_in_xram) begin
      xram_q[stack_addr] <= mem_req_in.wdata;
    end else if (move_q && move_int_q && move_wr_q && cyc_left_q == 4'h1)
    begin
      xram_q[bus_q.addr[10:0]] <= bus_q.wdata;
    end
  end
  // read data one cycle after the request
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else if (pop && stack_in_xram) begin
      rdata_q <= xram_q[stack_addr];
    end else if (mem_req_in.op == core_map_pkg::MEM_BIT) begin
      rdata_q <= {7'h00, old_byte[mem_req_in.addr[2:0]]};
    end else begin
      rdata_q <= old_byte;
    end
  end
  assign mem_rdata_out = rdata_q;

  // ---------------------------------------------------------------
  // special function registers
  // ---------------------------------------------------------------
  logic sfr_we;
  assign sfr_we = byte_we && is_sfr;

  // stack pointer: push and pop win over direct writes
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_ptr_low_q <= core_map_pkg::SP_RESET;
      stack_ptr_high_q <= core_map_pkg::SPH_RESET;
    end else if (push || pop) begin
      stack_ptr_low_q <= push ? sp_next[7:0] : sp_prev[7:0];
      stack_ptr_high_q <= {5'h00, push ? sp_next[10:8] : sp_prev[10:8]};
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_SP) begin
      stack_ptr_low_q <= new_byte;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_SPH) begin
      stack_ptr_high_q <= {5'h00, new_byte[2:0]};
    end
  end

  // wait states and configuration
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_data_move_wait_states_q <= core_map_pkg::EXT_DATA_MOVE_WAIT_STATES_RESET;
      core_config_reg_q <= core_map_pkg::CFG_RESET;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_EXT_DATA_MOVE_WAIT_STATES) begin
      ext_data_move_wait_states_q <= {5'h00, new_byte[2:0]};
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_CFG) begin
      core_config_reg_q <= new_byte;
    end
  end

  // status word; parity is never stored
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= core_map_pkg::PSW_RESET[7:1];
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_PSW) begin
      status_q <= new_byte[7:1];
    end
  end
  assign cpu_status_word_out = {status_q, parity};

  // accumulator: completing move read wins over a direct write
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_operand_reg_q <= 8'h00;
    end else if (move_q && !move_wr_q && cyc_left_q == 4'h1) begin
      main_operand_reg_q <= move_int_q ? xram_q[bus_q.addr[10:0]]
                                       : ext_data_in;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_ACC) begin
      main_operand_reg_q <= new_byte;
    end
  end

  // data pointer; increment carries through page byte
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {pointer_page_byte_q, pointer_high_byte_q, pointer_low_byte_q}
        <= 24'h000000;
    end else if (inc_pointer_in) begin
      {pointer_page_byte_q, pointer_high_byte_q, pointer_low_byte_q}
        <= data_pointer_word + 24'h000001;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_DPL) begin
      pointer_low_byte_q <= new_byte;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_DPH) begin
      pointer_high_byte_q <= new_byte;
    end else if (sfr_we && ram_idx == core_map_pkg::SFR_DPP) begin
      pointer_page_byte_q <= new_byte;
    end
  end
  assign data_pointer_word_out = data_pointer_word;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [3:0] move_cnt_q; // cycles of the running move
  logic [3:0] move_len_q; // its expected length
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      move_cnt_q <= 4'h0;
      move_len_q <= 4'h0;
    end else if (start
                 && instr_req_in.kind == core_map_pkg::INSTR_EXT_MOVE) begin
      move_cnt_q <= 4'h2; // the take edge opens the second cycle
      move_len_q <= core_map_pkg::MOVE_BASE_CYCLES
                    + {1'b0, ext_data_move_wait_states_q[2:0]};
    end else if (move_q) begin
      move_cnt_q <= move_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  chk_timer_tick: assert property (
    timer_run_in |=> timer_q == $past(timer_q) + 16'h0001)
    else $error("timer did not advance by one");
  chk_strobe_first: assert property (
    start && instr_len(instr_req_in, ext_data_move_wait_states_q[2:0]) > 4'h1
    |=> !start && !instr_ready_out)
    else $error("strobe cycle repeated inside instruction");
  chk_wait_range: assert property (
    ext_data_move_wait_states_q[7:3] == 5'h00)
    else $error("wait count above seven");
  chk_move_length: assert property (
    move_q && cyc_left_q == 4'h1 |-> move_cnt_q == move_len_q)
    else $error("external move length wrong");
  chk_irq_call: assert property (
    start && instr_req_in.kind == core_map_pkg::INSTR_IRQ_CALL
    |=> !instr_ready_out [*2] ##1 instr_ready_out)
    else $error("interrupt call not three cycles");
  chk_nop_fetch: assert property (
    code_addr_in >= core_map_pkg::NOP_AREA_START
    |=> code_data_out == core_map_pkg::NOP_OPCODE)
    else $error("top code area did not read no-op");
  chk_push_step: assert property (
    push && !xstack |=> stack_ptr_low_q == $past(stack_ptr_low_q) + 8'h01)
    else $error("push did not pre-increment pointer");
  chk_pointer_carry: assert property (
    inc_pointer_in |=> data_pointer_word == $past(data_pointer_word) + 24'h000001)
    else $error("pointer increment lost carry");
  chk_strobe_release: assert property (
    move_q && cyc_left_q == 4'h1 |=> bus_q.rd_n && bus_q.wr_n)
    else $error("strobe held past move end");

  cov_move_waits: cover property (
    start && instr_req_in.kind == core_map_pkg::INSTR_EXT_MOVE
    && ext_data_move_wait_states_q[2:0] != 3'h0);
  cov_push_xram: cover property (push && stack_in_xram);
  cov_irq_call: cover property (
    start && instr_req_in.kind == core_map_pkg::INSTR_IRQ_CALL);
endmodule : core_map

// [tb/ext_ram_model.sv]
/*
  ext_ram_model: asynchronous external data ram on the core's bus.
  assumes: active low strobes; no pull on the data lines.
*/
`timescale 1ns/1ps
module ext_ram_model (
  input wire logic clk_sys_in,
  input wire core_map_pkg::ext_bus_s bus_in,
  output logic [7:0] data_out
);
  logic [7:0] last_q; // last value put on the lines
  logic [7:0] stored_byte; // byte stored at the strobed address
  // contents are a fixed function of the 24-bit address
  assign stored_byte = bus_in.addr[7:0] ^ bus_in.addr[23:16] ^ 8'h3c;
  // released lines show the inverse of the last value, never a copy
  assign data_out = !bus_in.rd_n ? stored_byte : ~last_q;
  always_ff @(posedge clk_sys_in) begin
    if (!bus_in.rd_n) begin
      last_q <= stored_byte;
    end
  end
endmodule : ext_ram_model

// [tb/tb_core_map.sv]
/*
  tb_core_map: directed test of the core memory map block.
  assumes: ext_ram_model on the external bus; one 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_core_map;
  logic clk_sys_in = 0;
  logic reset_n_in = 0;
  core_map_pkg::instr_req_s ireq = '0;
  core_map_pkg::mem_req_s mreq = '0;
  core_map_pkg::ext_bus_s bus;
  logic ivalid = 0, irdy, ale, trun = 0, incp = 0, free;
  logic [15:0] tcnt, caddr = '0;
  logic [7:0] flash = '0, cdata, rd, cpu_status_word, xdata;
  logic [23:0] ptr;
  int failures = 0, num_checks = 0, cyc = 0, n;
  core_map dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .instr_req_in(ireq), .instr_valid_in(ivalid), .instr_ready_out(irdy),
    .ale_out(ale), .timer_run_in(trun), .timer_count_out(tcnt),
    .code_addr_in(caddr), .code_flash_in(flash), .code_data_out(cdata),
    .mem_req_in(mreq), .mem_rdata_out(rd), .inc_pointer_in(incp),
    .data_pointer_word_out(ptr), .cpu_status_word_out(cpu_status_word),
    .ext_data_in(xdata), .ext_bus_out(bus), .bus_ports_free_out(free));
  ext_ram_model ram (.clk_sys_in(clk_sys_in), .bus_in(bus),
    .data_out(xdata));
  // ---------------------------------------------------------------
  // clock and run limit
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one memory-port access; read data settled on return
  task automatic acc(input logic [2:0] op, input logic wr,
    input logic [7:0] a, d);
    @(posedge clk_sys_in) mreq <= '{core_map_pkg::mem_op_e'(op), wr, a, d};
    @(posedge clk_sys_in) mreq.op <= core_map_pkg::MEM_NONE;
    #1;
  endtask : acc
  // start one instruction, count cycles until ready returns
  task automatic ins(input logic [1:0] k, input logic [3:0] c,
    input int len);
    @(posedge clk_sys_in) ireq <= '{core_map_pkg::instr_kind_e'(k), c, 1'b0};
    ivalid <= 1;
    #1 chk("ale high", ale, 1'b1);
    #5 chk("ale low", ale, 1'b0);
    @(posedge clk_sys_in) ivalid <= 0;
    #1;
    n = 1;
    while (irdy !== 1'b1 && n < 40) begin
      @(posedge clk_sys_in);
      #1;
      chk("ale quiet", ale, 1'b0);
      n++;
    end
    chk("length", n, len);
  endtask : ins
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1;
    acc(1, 0, 8'h81, 0); chk("sp", rd, 8'h07);
    acc(1, 0, 8'hd0, 0); chk("psw", rd, 8'h00);
    acc(1, 0, 8'h9f, 0); chk("wait", rd, 8'h00);
    acc(1, 1, 8'h9f, 8'h07); acc(1, 0, 8'h9f, 0);
    chk("wait max", rd, 8'h07);
    acc(5, 1, 0, 8'ha5); acc(1, 0, 8'h81, 0); chk("sp push", rd, 8'h08);
    acc(2, 0, 8'h08, 0); chk("stacked", rd, 8'ha5);
    acc(1, 1, 8'hd0, 8'h10); acc(3, 1, 3, 8'h66);
    acc(2, 0, 8'h13, 0); chk("bank2 r3", rd, 8'h66);
    acc(2, 1, 8'h21, 0); acc(4, 1, 8'h0a, 1);
    acc(2, 0, 8'h21, 0); chk("bit 0a", rd, 8'h04);
    acc(2, 1, 8'h90, 8'h5a); acc(1, 0, 8'h90, 0);
    chk("direct 90", rd, 8'h00);
    acc(2, 0, 8'h90, 0); chk("upper ram", rd, 8'h5a);
    acc(1, 1, 8'h82, 8'hff); acc(1, 1, 8'h83, 8'hff);
    @(posedge clk_sys_in) incp <= 1;
    @(posedge clk_sys_in) incp <= 0;
    #1 chk("pointer", ptr, 24'h010000);
    acc(1, 1, 8'h9f, 8'h02); ins(1, 0, 6);
    acc(1, 0, 8'he0, 0); chk("moved", rd, 8'h3d);
    chk("parity", cpu_status_word[0], 1'b1);
    ins(0, 1, 1);
    ins(0, 4, 4);
    ins(2, 0, 3);
    @(posedge clk_sys_in) caddr <= 16'hf7ff;
    flash <= 8'hff;
    @(posedge clk_sys_in) caddr <= 16'hf800;
    #1 chk("code", cdata, 8'hff);
    @(posedge clk_sys_in) #1 chk("nop area", cdata, 8'h00);
    @(posedge clk_sys_in) trun <= 1;
    @(posedge clk_sys_in) #1 n = tcnt;
    repeat (10) @(posedge clk_sys_in);
    #1 chk("timer", tcnt, n + 10);
    acc(1, 1, 8'haf, 8'h01); @(posedge clk_sys_in);
    #1 chk("ports free", free, 1'b1);
    acc(1, 1, 8'h81, 8'hff); acc(1, 1, 8'haf, 8'h80); acc(5, 1, 0, 8'h77);
    acc(1, 0, 8'hb7, 0); chk("sph", rd, 8'h01);
    acc(1, 0, 8'h81, 0); chk("sp low", rd, 8'h00);
    acc(5, 0, 0, 0); chk("pop xram", rd, 8'h77);
    acc(1, 0, 8'h81, 0); chk("sp back", rd, 8'hff);
    acc(1, 1, 8'haf, 8'h00); acc(5, 1, 0, 8'h11);
    acc(1, 0, 8'h81, 0); chk("sp wrap", rd, 8'h00);
    acc(2, 0, 8'h00, 0); chk("wrapped", rd, 8'h11);
    report_and_stop();
  end
endmodule : tb_core_map
